// ===== hdl/lsix_pkg.sv
// Purpose: constants for the standard instruction executor
// Assumes: 10 MHz pclk stands in for the oscillator
// Notes: register offsets are byte addresses on APB
package lsix_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] ADDR_CMD = 12'h0000;
    localparam logic [11:0] ADDR_DATA = 12'h0004;
    localparam logic [11:0] ADDR_STATUS = 12'h0008;
    localparam logic [11:0] ADDR_CTRL = 12'h000C;
    localparam logic [11:0] ADDR_VIEW = 12'h0010;
    localparam logic [11:0] ADDR_RDATA = 12'h0014;
    // ----------------------------------------
    // Instruction codes and fields
    // ----------------------------------------
    localparam logic [7:0] CODE_BLANK = 8'h01;
    localparam logic [7:0] CODE_HOME = 8'h02;
    localparam logic [7:0] BLANK_CHAR = 8'h20;
    localparam int BIT_STEP_DIR = 1;
    localparam int BIT_SHIFT_WR = 0;
    localparam int BIT_DISP = 2;
    localparam int BIT_CURSOR = 1;
    localparam int BIT_BLINK = 0;
    localparam int BIT_TARGET = 3;
    localparam int BIT_SDIR = 2;
    // ----------------------------------------
    // Timing in oscillator cycles, then line length and RAM depths
    // ----------------------------------------
    localparam int CYC_BLANK = 165;
    localparam int CYC_STD = 3;
    localparam int CYC_OFF = 3;
    localparam int BLINK_DIV = 52224;
    localparam int HALF_BLINK = BLINK_DIV / 2;
    localparam int LINE_LEN = 40;
    localparam int TEXT_DEPTH = 128;
    localparam int GLYPH_DEPTH = 64;
endpackage : lsix_pkg

// ===== hdl/lsix_exec.sv
// Purpose: standard instruction group of a character display controller
// Assumes: APB slave, one clock, instructions and data written as registers
// Notes: single flop state struct; outputs come from flops
//
// Operation
// - Standard group decodes only while instruction-set select is zero.
// - Blank-all command fills every text location with code 20h.
// - Blank-all clears pointer and display shift, cursor goes left.
// - Blank-all forces increment, keeps shift-on-write unchanged.
// - Blank-all holds busy 165 cycles; host polls or waits.
// - Home clears pointer and shift, keeps RAM and entry bits.
// - Step bit chooses increment or decrement after each data access.
// - Shift-on-write scrolls display on text writes, direction from step.
// - No scroll on text reads or any glyph access.
// - Cursor and blink suppressed while glyph RAM selected.
// - Display bit zero turns panel off into partial power-down.
// - Outputs grounded three cycles after off; host waits before stopping.
// - Instructions still execute while display is off.
// - Cursor bit draws underline; stepping continues when cursor hidden.
// - Blink alternates at oscillator divided by 52224.
// - Move-or-scroll moves cursor or scrolls, left or right, no RAM.
// - Cursor wraps past 40 in two-line mode; lines scroll together.
// - Scroll keeps pointer; cursor move steps pointer.
// - Glyph pointer load sets bits 5..0, keeps bit 6, selects glyph.
// - Text pointer load sets all seven bits and selects text RAM.
// - No new instruction executes while busy is one.
// - Pointer loads refresh read data; other commands keep it.
`timescale 1ns/1ps
module lsix_exec #(
    parameter int BLINK_HALF = lsix_pkg::HALF_BLINK
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy_indicator,
    output logic [6:0] ram_pointer,
    output logic display_on,
    output logic outputs_grounded,
    output logic cursor_visible,
    output logic blink_phase,
    output logic [5:0] view_shift
);
    import lsix_pkg::*;

    typedef enum {ST_IDLE, ST_BLANK, ST_WAIT} lsix_state_t;

    typedef struct packed {
        lsix_state_t st;
        logic [7:0] cnt;
        logic [6:0] ptr;
        logic glyph_sel;
        logic step_inc;
        logic shift_wr;
        logic disp;
        logic cursor;
        logic blink;
        logic ext_set;
        logic two_line;
        logic [5:0] shift;
        logic [1:0] off_cnt;
        logic grounded;
        logic [15:0] blink_cnt;
        logic blink_ph;
        logic [7:0] rdata;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic busy;
        logic cur_vis;
        logic blink_out;
    } lsix_reg_t;

    lsix_reg_t r;
    lsix_reg_t next_r;
    logic [7:0] text_ram [TEXT_DEPTH];
    logic [7:0] glyph_ram [GLYPH_DEPTH];
    logic [7:0] mem_wdata;
    logic [6:0] mem_waddr;
    logic text_we;
    logic glyph_we;
    logic [7:0] rd_text;
    logic [7:0] rd_glyph;
    logic cmd_take;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Step pointer modulo 128, with two-line wrap past 40
    function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic inc,
                                            input logic two);
        logic [6:0] n;
        n = inc ? p + 7'd1 : p - 7'd1;
        if (two && inc && p == 7'(LINE_LEN - 1)) begin
            n = 7'h40;
        end else if (two && !inc && p == 7'h40) begin
            n = 7'(LINE_LEN - 1);
        end
        return n;
    endfunction : step_ptr

    // Shift counter wraps over one line so all lines move together
    function automatic logic [5:0] step_shift(input logic [5:0] s, input logic left);
        logic [5:0] n;
        n = s;
        if (left) begin
            n = (s == 6'(LINE_LEN - 1)) ? 6'd0 : s + 6'd1;
        end else begin
            n = (s == 6'd0) ? 6'(LINE_LEN - 1) : s - 6'd1;
        end
        return n;
    endfunction : step_shift

    assign rd_text = text_ram[r.ptr];
    assign rd_glyph = glyph_ram[r.ptr[5:0]];

    // Command write accepted this cycle, for the checks below
    assign cmd_take = psel && penable && pwrite && !r.pready && paddr == ADDR_CMD
        && r.st == ST_IDLE && !r.ext_set;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic wr;
        logic rd;
        logic [7:0] c;
        logic [6:0] np;
        wr = psel && penable && pwrite;
        rd = psel && penable && !pwrite;
        c = pwdata[7:0];
        np = 7'd0;
        next_r = r;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        mem_wdata = BLANK_CHAR;
        mem_waddr = r.cnt[6:0];
        text_we = 1'b0;
        glyph_we = 1'b0;
        // Blink divider runs from the oscillator
        if (r.blink_cnt == 16'(BLINK_HALF - 1)) begin
            next_r.blink_cnt = 16'h0000;
            next_r.blink_ph = ~r.blink_ph;
        end else begin
            next_r.blink_cnt = r.blink_cnt + 16'h0001;
        end
        // Grounding of panel outputs after display off
        if (r.disp) begin
            next_r.off_cnt = 2'd0;
            next_r.grounded = 1'b0;
        end else if (!r.grounded) begin
            if (r.off_cnt == 2'(CYC_OFF - 1)) begin
                next_r.grounded = 1'b1;
            end else begin
                next_r.off_cnt = r.off_cnt + 2'd1;
            end
        end
        // Execution timer
        case (r.st)
            ST_IDLE: begin
            end
            ST_BLANK: begin
                text_we = 1'b1;
                if (r.cnt == 8'(CYC_BLANK - 1)) begin
                    next_r.st = ST_IDLE;
                end
                next_r.cnt = r.cnt + 8'd1;
            end
            ST_WAIT: begin
                if (r.cnt == 8'(CYC_STD - 1)) begin
                    next_r.st = ST_IDLE;
                end
                next_r.cnt = r.cnt + 8'd1;
            end
            default: next_r.st = ST_IDLE;
        endcase
        // APB access, answered in the access phase
        if (psel && penable && !r.pready) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            case (paddr)
                ADDR_CMD: begin
                    // Commands ignored while busy or in extended set
                    if (wr && r.st == ST_IDLE && !r.ext_set) begin
                        next_r.st = ST_WAIT;
                        next_r.cnt = 8'd0;
                        if (c == CODE_BLANK) begin
                            next_r.st = ST_BLANK;
                            next_r.ptr = 7'd0;
                            next_r.shift = 6'd0;
                            next_r.step_inc = 1'b1;
                        end else if (c == CODE_HOME) begin
                            next_r.ptr = 7'd0;
                            next_r.shift = 6'd0;
                        end else if (c[7:2] == 6'b0000_01) begin
                            next_r.step_inc = c[BIT_STEP_DIR];
                            next_r.shift_wr = c[BIT_SHIFT_WR];
                        end else if (c[7:3] == 5'b0000_1) begin
                            next_r.disp = c[BIT_DISP];
                            next_r.cursor = c[BIT_CURSOR];
                            next_r.blink = c[BIT_BLINK];
                        end else if (c[7:4] == 4'b0001 && c[1:0] == 2'b00) begin
                            if (c[BIT_TARGET]) begin
                                next_r.shift = step_shift(r.shift, !c[BIT_SDIR]);
                            end else begin
                                next_r.ptr = step_ptr(r.ptr, c[BIT_SDIR], r.two_line);
                            end
                        end else if (c[7:6] == 2'b01) begin
                            np = {r.ptr[6], c[5:0]};
                            next_r.ptr = np;
                            next_r.glyph_sel = 1'b1;
                            next_r.rdata = glyph_ram[np[5:0]];
                        end else if (c[7]) begin
                            np = c[6:0];
                            next_r.ptr = np;
                            next_r.glyph_sel = 1'b0;
                            next_r.rdata = text_ram[np];
                        end
                    end
                end
                ADDR_DATA: begin
                    if (r.st == ST_IDLE) begin
                        np = step_ptr(r.ptr, r.step_inc, r.two_line);
                        next_r.ptr = np;
                        next_r.st = ST_WAIT;
                        next_r.cnt = 8'd0;
                        if (wr) begin
                            mem_wdata = c;
                            mem_waddr = r.ptr;
                            text_we = !r.glyph_sel;
                            glyph_we = r.glyph_sel;
                            if (r.shift_wr && !r.glyph_sel) begin
                                next_r.shift = step_shift(r.shift, r.step_inc);
                            end
                        end else if (rd) begin
                            next_r.prdata = {24'h00_0000, r.rdata};
                            next_r.rdata = r.glyph_sel ? glyph_ram[np[5:0]] : text_ram[np];
                        end
                    end else begin
                        next_r.pslverr = 1'b1;
                    end
                end
                ADDR_STATUS: begin
                    next_r.prdata = {24'h00_0000, r.st != ST_IDLE, r.ptr};
                end
                ADDR_CTRL: begin
                    if (wr) begin
                        next_r.ext_set = pwdata[0];
                        next_r.two_line = pwdata[1];
                    end
                    next_r.prdata = {30'h0000_0000, r.two_line, r.ext_set};
                end
                ADDR_VIEW: begin
                    next_r.prdata = {16'h0000, 2'b00, r.shift, r.grounded,
                                     r.glyph_sel, r.step_inc, r.shift_wr, r.disp,
                                     r.cursor, r.blink, r.blink_ph};
                end
                ADDR_RDATA: begin
                    next_r.prdata = {16'h0000, rd_glyph, rd_text};
                end
                default: next_r.pslverr = 1'b1;
            endcase
        end
        // Status outputs registered from the next state, so they leave a flop
        next_r.busy = (next_r.st != ST_IDLE);
        next_r.cur_vis = next_r.cursor && !next_r.glyph_sel;
        next_r.blink_out = next_r.blink && !next_r.glyph_sel && next_r.blink_ph;
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{st: ST_IDLE, step_inc: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // RAM write port, no reset on contents
    always_ff @(posedge pclk) begin
        if (text_we) begin
            text_ram[mem_waddr] <= mem_wdata;
        end
        if (glyph_we) begin
            glyph_ram[mem_waddr[5:0]] <= mem_wdata;
        end
    end

    // Outputs
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign busy_indicator = r.busy;
    assign ram_pointer = r.ptr;
    assign display_on = r.disp;
    assign outputs_grounded = r.grounded;
    assign cursor_visible = r.cur_vis;
    assign blink_phase = r.blink_out;
    assign view_shift = r.shift;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_blank_busy: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(r.st == ST_BLANK) |-> (r.st == ST_BLANK) [*8])
        else $error("blank command ended early");
    a_blank_home: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(r.st == ST_BLANK) |-> r.ptr == 7'd0 && r.shift == 6'd0 && r.step_inc)
        else $error("blank did not home");
    a_off_ground: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(r.disp) |-> ##3 r.grounded)
        else $error("outputs not grounded in time");
    a_glyph_cursor: assert property (@(posedge pclk) disable iff (!presetn)
        r.glyph_sel |-> !cursor_visible && !blink_phase)
        else $error("cursor shown during glyph access");
    a_busy_hold: assert property (@(posedge pclk) disable iff (!presetn)
        busy_indicator && !text_we |=> $stable(r.disp) && $stable(r.step_inc))
        else $error("command run while busy");
    a_ext_block: assert property (@(posedge pclk) disable iff (!presetn)
        r.ext_set && !(psel && paddr == ADDR_CTRL) |=> $stable(r.disp) && $stable(r.cursor))
        else $error("standard command in extended set");
    a_glyph_bit6: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(r.glyph_sel) |-> r.ptr[6] == $past(r.ptr[6]))
        else $error("glyph load changed bit 6");
    a_scroll_ptr: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && pwdata[7:3] == 5'b0_0011 && pwdata[1:0] == 2'b00 |=> $stable(r.ptr))
        else $error("scroll moved pointer");
    a_move_ptr: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && pwdata[7:3] == 5'b0_0010 && pwdata[1:0] == 2'b00 |=> !$stable(r.ptr))
        else $error("cursor move kept pointer");
    c_blank: cover property (@(posedge pclk) disable iff (!presetn) $fell(r.st == ST_BLANK));
    c_glyph: cover property (@(posedge pclk) disable iff (!presetn) glyph_we);
    c_scroll: cover property (@(posedge pclk) disable iff (!presetn) $changed(r.shift));
    c_move: cover property (@(posedge pclk) disable iff (!presetn) cmd_take && pwdata[7:4] == 4'b0001);
    c_ground: cover property (@(posedge pclk) disable iff (!presetn) $rose(r.grounded));
endmodule : lsix_exec

// ===== bench/lsix_host.sv
// Purpose: host model issuing display instructions over APB
// Assumes: slave answers within 20 edges of the access phase
// Notes: released address and data lines carry the inverse value
`timescale 1ns/1ps
module lsix_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic hang
);
    import lsix_pkg::*;
    // ----------------------------------------
    // Bus master
    // ----------------------------------------
    // Bus idle at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        hang = 1'b0;
    end
    // One transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang <= 1'b1;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
    // Poll busy until clear, so no instruction lands while busy
    task automatic idle();
        logic [31:0] q;
        logic e;
        int n;
        n = 0;
        do begin
            xfer(1'b0, ADDR_STATUS, 32'h0, q, e);
            n++;
        end while (q[7] !== 1'b0 && n < 200);
        if (n >= 200) hang <= 1'b1;
    endtask : idle
    // Instruction write once busy has cleared
    task automatic cmd(input logic [7:0] c);
        logic [31:0] q;
        logic e;
        idle();
        xfer(1'b1, ADDR_CMD, {24'h00_0000, c}, q, e);
    endtask : cmd
endmodule : lsix_host

// ===== bench/testbench.sv
// Purpose: self-checking bench for the standard instruction executor
// Assumes: host model drives APB; blink half period cut to 4 cycles
// Notes: port checks follow a busy poll and a falling edge
`timescale 1ns/1ps
module testbench;
    import lsix_pkg::*;
    localparam int HALF = 4;
    logic pclk, presetn, e;
    wire psel, penable, pwrite, pready, pslverr, busy_indicator;
    wire display_on, outputs_grounded, cursor_visible, blink_phase, hang;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    logic [31:0] q;
    wire [6:0] ram_pointer;
    wire [5:0] view_shift;
    logic [5:0] vs;
    int error_cnt, tests_run, n, k, run, last;
    logic [7:0] mv [4] = '{8'h14, 8'h10, 8'h1C, 8'h18};
    logic [6:0] mp [4] = '{7'h01, 7'h00, 7'h00, 7'h00};
    logic ms [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic [7:0] ba [3] = '{8'h80, 8'h84, 8'hFF};
    // ----------------------------------------
    // Design, host and clock
    // ----------------------------------------
    lsix_exec #(.BLINK_HALF(HALF)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy_indicator(busy_indicator),
        .ram_pointer(ram_pointer), .display_on(display_on), .outputs_grounded(outputs_grounded),
        .cursor_visible(cursor_visible), .blink_phase(blink_phase), .view_shift(view_shift));
    lsix_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hang(hang));
    // Clock at 10 MHz
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Length of the latest busy stretch
    always @(posedge pclk) begin
        if (busy_indicator === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            last <= run;
            run <= 0;
        end
    end
    // A host wait that ran out ends the run
    always @(posedge hang) begin
        error_cnt++;
        $display("[FAIL] %0t host wait timed out", $time);
        report_and_stop();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cr(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("[FAIL] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask : cr
    task automatic cb(input logic got, input logic exp);
        chk(32'(got), 32'(exp));
    endtask : cb
    // Let busy clear and outputs settle
    task automatic settle();
        host_u.idle();
        @(negedge pclk);
    endtask : settle
    task automatic cp(input logic [6:0] exp);
        settle();
        chk(32'(ram_pointer), 32'(exp));
    endtask : cp
    task automatic wd(input logic [7:0] v);
        host_u.idle();
        host_u.xfer(1'b1, ADDR_DATA, {24'h00_0000, v}, q, e);
    endtask : wd
    task automatic rd(input logic [11:0] a);
        host_u.idle();
        host_u.xfer(1'b0, a, 32'h0, q, e);
    endtask : rd
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        error_cnt = 0;
        tests_run = 0;
        run = 0;
        last = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        cp(7'h00);
        repeat (4) @(posedge pclk);
        cb(outputs_grounded, 1'b1);
        $display("Test reset done");
        // Pointer load, step both ways, wrap at both ends
        host_u.cmd(8'hFF);
        cp(7'h7F);
        cr(last, CYC_STD, CYC_STD);
        host_u.cmd(8'h06);
        wd(8'h41);
        cp(7'h00);
        host_u.cmd(8'h04);
        wd(8'h42);
        cp(7'h7F);
        host_u.cmd(8'h06);
        host_u.cmd(8'hFF);
        rd(ADDR_DATA);
        chk(32'(q[7:0]), 32'h41);
        host_u.cmd(8'h14);
        rd(ADDR_DATA);
        chk(32'(q[7:0]), 32'h42);
        $display("Test pointer done");
        // Shift on text writes only, then home
        host_u.cmd(8'h07);
        host_u.cmd(8'h80);
        wd(8'h43);
        settle();
        cb(view_shift != 6'h00, 1'b1);
        vs = view_shift;
        rd(ADDR_DATA);
        settle();
        chk(32'(view_shift), 32'(vs));
        host_u.cmd(8'h05);
        wd(8'h44);
        settle();
        cb(view_shift == 6'h00, 1'b1);
        host_u.cmd(8'h07);
        wd(8'h45);
        host_u.cmd(CODE_HOME);
        cp(7'h00);
        cb(view_shift == 6'h00, 1'b1);
        rd(ADDR_VIEW);
        chk(32'(q[5:4]), 32'h3);
        $display("Test shift done");
        // Cursor moves and display scrolls
        for (k = 0; k < 4; k++) begin
            host_u.cmd(mv[k]);
            cp(mp[k]);
            cb(view_shift != 6'h00, ms[k]);
        end
        host_u.xfer(1'b1, ADDR_CTRL, 32'h2, q, e);
        host_u.cmd(8'hA7);
        host_u.cmd(8'h14);
        cp(7'h40);
        host_u.cmd(8'h10);
        cp(7'h27);
        $display("Test move done");
        // Glyph pointer keeps bit 6 and hides the cursor
        host_u.cmd(8'h0F);
        host_u.cmd(8'hC0);
        settle();
        cb(cursor_visible, 1'b1);
        host_u.cmd(8'h45);
        cp(7'h45);
        cb(cursor_visible, 1'b0);
        cb(blink_phase, 1'b0);
        repeat (HALF + 1) @(negedge pclk);
        cb(blink_phase, 1'b0);
        host_u.cmd(8'h80);
        host_u.cmd(8'h45);
        cp(7'h05);
        host_u.cmd(8'h07);
        wd(8'h55);
        cp(7'h06);
        cb(view_shift == 6'h00, 1'b1);
        $display("Test glyph done");
        // Blank-all with refused requests while busy
        host_u.cmd(8'h05);
        host_u.cmd(8'h85);
        wd(8'h66);
        host_u.idle();
        host_u.xfer(1'b1, ADDR_CMD, 32'(CODE_BLANK), q, e);
        host_u.xfer(1'b0, ADDR_DATA, 32'h0, q, e);
        cb(e, 1'b1);
        host_u.xfer(1'b1, ADDR_CMD, 32'h90, q, e);
        cp(7'h00);
        cr(last, CYC_BLANK, CYC_BLANK);
        cb(view_shift == 6'h00, 1'b1);
        rd(ADDR_VIEW);
        chk(32'(q[5:4]), 32'h3);
        for (k = 0; k < 3; k++) begin
            host_u.cmd(ba[k]);
            rd(ADDR_RDATA);
            chk(32'(q[7:0]), 32'(BLANK_CHAR));
        end
        rd(12'h020);
        cb(e, 1'b1);
        $display("Test blank done");
        // Display off, work while off, then back on
        host_u.cmd(8'h08);
        for (n = 0; n < 20 && outputs_grounded !== 1'b1; n++) @(posedge pclk);
        cr(n, CYC_OFF - 1, CYC_OFF + 1);
        settle();
        cb(display_on, 1'b0);
        host_u.cmd(8'h83);
        cp(7'h03);
        wd(BLANK_CHAR);
        host_u.cmd(8'h0C);
        cp(7'h04);
        cb(display_on, 1'b1);
        cb(outputs_grounded, 1'b0);
        cb(cursor_visible, 1'b0);
        host_u.xfer(1'b1, ADDR_CTRL, 32'h1, q, e);
        host_u.cmd(CODE_HOME);
        cp(7'h04);
        host_u.xfer(1'b1, ADDR_CTRL, 32'h0, q, e);
        host_u.cmd(CODE_HOME);
        cp(7'h00);
        $display("Test power done");
        // Blink low phase from a fall to the next rise
        host_u.cmd(8'h0D);
        for (n = 0; n < 50 && blink_phase !== 1'b1; n++) @(posedge pclk);
        for (n = 0; n < 50 && blink_phase !== 1'b0; n++) @(posedge pclk);
        for (n = 0; n < 50 && blink_phase !== 1'b1; n++) @(posedge pclk);
        cr(n, HALF, HALF);
        $display("Test blink done");
        report_and_stop();
    end
endmodule : testbench
